// ---- design/cfgtwo_bank.sv ----
/*
 * second controller setup register bank, upper fields: capture delay,
 * memory protocol and bus width, with strap defaults and a wishbone port.
 * assumes straps are stable around reset release and the memory-side
 * reset is synchronous to i_mclk.
 */
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "cfgtwo_params.svh"

// Overview of operation
// - bits 31:11 written zero, read zero here
// - capture delay field 10:9, values 0..2
// - fields load straps at reset release
// - protocol changeable only in combined builds
// - decode codes 000..011 to four protocols
// - code 100 combined, 101..111 reserved
// - status field reports supported protocols
// - width field picks full or lower half
// - 32-bit bus: 00 half, 01 full
// - 64-bit bus: 01 half, 10 full
// - software writes in setup or sleep state override strap values
module cfgtwo_bank #(
   parameter int         BUS_BITS = 32,
   parameter logic       COMBINED = 1'b1,
   parameter logic [4:0] SUPPORT  = 5'h1F
) (
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_mem_rst_n,
   // straps
   input  wire logic [1:0]  i_strap_delay,
   input  wire logic [2:0]  i_strap_prot,
   input  wire logic [1:0]  i_strap_width,
   // wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output      logic [31:0] o_wb_dat,
   output      logic        o_wb_ack,
   // configuration out
   output      logic [1:0]  o_capture_delay,
   output      cfgtwo_pkg::cfgtwo_prot_type o_protocol,
   output      logic [4:0]  o_protocol_sel,
   output      logic [6:0]  o_bus_bits,
   output      logic [7:0]  o_lane_mask
);
   import cfgtwo_pkg::*;

   logic [1:0]      delay_r;       // capture delay field
   logic [2:0]      prot_r;        // protocol field
   logic [1:0]      width_r;       // width field
   logic [1:0]      state_r;       // controller state
   logic            rst_d_r;       // reset seen last cycle
   logic            mem_rst_d_r;   // memory reset seen last cycle
   logic [1:0]      width_act_r;   // width in force on the pads
   cfgtwo_bus_type  bus_r;         // bus phase
   logic [31:0]     rdat_nxt;      // read mux
   logic            req;           // new request
   logic            wr_ok;         // write window open
   logic [4:0]      sel_dec;       // decoder select
   cfgtwo_prot_type prot_dec;      // decoder protocol

   // delay value clamped to the supported range
   function automatic logic [1:0] clamp_dly(input logic [1:0] d);
      clamp_dly = (d > `CFGTWO_DLY_MAX) ? `CFGTWO_DLY_MAX : d;
   endfunction

   // a fresh request while no ack is out
   assign req   = i_wb_cyc && i_wb_stb && (bus_r == CFGTWO_IDLE);
   // only setup and sleep accept configuration writes
   assign wr_ok = (state_r == `CFGTWO_ST_SETUP) || (state_r == `CFGTWO_ST_SLEEP);

   // track reset to find its release edge
   always_ff @(posedge i_mclk) begin
      rst_d_r <= i_rst_n;
   end

   // bus phase: ack one cycle after request, drop the next
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         bus_r <= CFGTWO_IDLE;
      end else begin
         case (bus_r)
            CFGTWO_IDLE: begin
               if (req) begin
                  bus_r <= CFGTWO_ACK;
               end
            end
            CFGTWO_ACK: begin
               bus_r <= CFGTWO_IDLE;
            end
            default: begin
               bus_r <= CFGTWO_IDLE;
            end
         endcase
      end
   end

   assign o_wb_ack = (bus_r == CFGTWO_ACK);

   // controller state register written by software
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state_r <= `CFGTWO_STATE_RST;
      end else if (req && i_wb_we && i_wb_sel[0]
                   && i_wb_adr == `CFGTWO_OFF_STATE) begin
         state_r <= i_wb_dat[1:0];
      end
   end

   // capture delay field
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         delay_r <= 2'h0;
      end else if (!rst_d_r) begin
         delay_r <= clamp_dly(i_strap_delay);
      end else if (req && i_wb_we && wr_ok && i_wb_sel[1]
                   && i_wb_adr == `CFGTWO_OFF_SETUP_TWO) begin
         delay_r <= clamp_dly(i_wb_dat[`CFGTWO_DLY_HI:`CFGTWO_DLY_LO]);
      end
   end

   // protocol field, held to strap unless combined build
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         prot_r <= 3'h0;
      end else if (!rst_d_r) begin
         prot_r <= i_strap_prot;
      end else if (COMBINED && req && i_wb_we && wr_ok
                   && (i_wb_sel[0] || i_wb_sel[1])
                   && i_wb_adr == `CFGTWO_OFF_SETUP_TWO) begin
         // field spans byte lanes 0 and 1; either lane updates its part
         prot_r <= {i_wb_sel[1] ? i_wb_dat[8] : prot_r[2],
                    i_wb_sel[0] ? i_wb_dat[7:6] : prot_r[1:0]};
      end
   end

   // width field, stored now and applied on memory reset release
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         width_r <= 2'h0;
      end else if (!rst_d_r) begin
         width_r <= i_strap_width;
      end else if (req && i_wb_we && wr_ok && i_wb_sel[0]
                   && i_wb_adr == `CFGTWO_OFF_SETUP_TWO) begin
         width_r <= i_wb_dat[`CFGTWO_WID_HI:`CFGTWO_WID_LO];
      end
   end

   // memory reset edge tracker
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         mem_rst_d_r <= 1'b0;
      end else begin
         mem_rst_d_r <= i_mem_rst_n;
      end
   end

   // width in force changes only as memory reset is released; when the
   // memory side is already out of reset at system reset release, the
   // strap value is the one that must reach the pads, not the cleared field
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         width_act_r <= 2'h0;
      end else if (i_mem_rst_n && !mem_rst_d_r) begin
         width_act_r <= rst_d_r ? width_r : i_strap_width;
      end
   end

   // read mux; unused bits read zero
   always_comb begin
      rdat_nxt = 32'h0000_0000;
      case (i_wb_adr)
         `CFGTWO_OFF_SETUP_TWO: begin
            rdat_nxt[`CFGTWO_DLY_HI:`CFGTWO_DLY_LO]   = delay_r;
            rdat_nxt[`CFGTWO_PROT_HI:`CFGTWO_PROT_LO] = prot_r;
            rdat_nxt[`CFGTWO_WID_HI:`CFGTWO_WID_LO]   = width_r;
         end
         `CFGTWO_OFF_STATUS: begin
            rdat_nxt[4:0] = SUPPORT;
            rdat_nxt[5]   = COMBINED;
         end
         `CFGTWO_OFF_STATE: begin
            rdat_nxt[1:0] = state_r;
         end
         default: begin
            rdat_nxt = 32'h0000_0000;
         end
      endcase
   end

   // read data register, loaded with the request
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (req) begin
         o_wb_dat <= rdat_nxt;
      end
   end

   // protocol decode
   cfgtwo_prot_dec u_prot (
      .i_code    (prot_r),
      .i_support (SUPPORT),
      .o_prot    (prot_dec),
      .o_sel     (sel_dec)
   );

   // width decode
   cfgtwo_width_dec #(
      .BUS_BITS (BUS_BITS)
   ) u_width (
      .i_code  (width_act_r),
      .o_bits  (o_bus_bits),
      .o_lanes (o_lane_mask)
   );

   assign o_capture_delay = delay_r;
   assign o_protocol      = prot_dec;
   assign o_protocol_sel  = sel_dec;
endmodule // cfgtwo_bank

// ---- inc/cfgtwo_params.svh ----
/*
 * timing-free constants for the second controller setup register:
 * offsets, field positions, reset values and decode codes.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef CFGTWO_PARAMS_SVH
`define CFGTWO_PARAMS_SVH

// register offsets (byte addresses, one aligned word each)
`define CFGTWO_OFF_SETUP_TWO  8'h00
`define CFGTWO_OFF_STATUS     8'h04
`define CFGTWO_OFF_STATE      8'h08

// field positions in the setup register
`define CFGTWO_DLY_HI   10
`define CFGTWO_DLY_LO   9
`define CFGTWO_PROT_HI  8
`define CFGTWO_PROT_LO  6
`define CFGTWO_WID_HI   5
`define CFGTWO_WID_LO   4

// protocol codes
`define CFGTWO_PROT_SDR    3'h0
`define CFGTWO_PROT_DDR    3'h1
`define CFGTWO_PROT_EDRAM  3'h2
`define CFGTWO_PROT_LPDDR  3'h3
`define CFGTWO_PROT_COMB   3'h4

// width codes
`define CFGTWO_WID_00  2'h0
`define CFGTWO_WID_01  2'h1
`define CFGTWO_WID_10  2'h2

// largest supported capture delay
`define CFGTWO_DLY_MAX  2'h2

// controller state codes for the access window
`define CFGTWO_ST_SETUP  2'h0
`define CFGTWO_ST_SLEEP  2'h3

// reset value of the controller state register
`define CFGTWO_STATE_RST 2'h0

`endif

// ---- inc/cfgtwo_pkg.sv ----
/*
 * types shared by the setup register bank.
 * assumes cfgtwo_params.svh on the include path.
 */
`include "cfgtwo_params.svh"
package cfgtwo_pkg;
   // decoded memory protocol
   typedef enum logic [2:0] {
      CFGTWO_SDR   = 3'b000,
      CFGTWO_DDR   = 3'b001,
      CFGTWO_EDRAM = 3'b010,
      CFGTWO_LPDDR = 3'b011,
      CFGTWO_COMB  = 3'b100,
      CFGTWO_RSVD  = 3'b111
   } cfgtwo_prot_type;

   // bus slave phase
   typedef enum logic [1:0] {
      CFGTWO_IDLE = 2'b00,
      CFGTWO_ACK  = 2'b01
   } cfgtwo_bus_type;
endpackage

// ---- design/cfgtwo_prot_dec.sv ----
/*
 * protocol decoder: turns the stored protocol code into a one-hot select
 * and a support check. assumes a protocol support mask from the top.
 */
`timescale 1ns/1ns
`include "cfgtwo_params.svh"
module cfgtwo_prot_dec (
   // code in
   input  wire logic [2:0]               i_code,
   input  wire logic [4:0]               i_support,
   // decoded out
   output      cfgtwo_pkg::cfgtwo_prot_type o_prot,
   output      logic [4:0]               o_sel
);
   import cfgtwo_pkg::*;

   // decode the code; reserved codes select nothing
   always_comb begin
      o_sel  = 5'h00;
      o_prot = CFGTWO_RSVD;
      case (i_code)
         `CFGTWO_PROT_SDR: begin
            o_sel  = 5'h01;
            o_prot = CFGTWO_SDR;
         end
         `CFGTWO_PROT_DDR: begin
            o_sel  = 5'h02;
            o_prot = CFGTWO_DDR;
         end
         `CFGTWO_PROT_EDRAM: begin
            o_sel  = 5'h04;
            o_prot = CFGTWO_EDRAM;
         end
         `CFGTWO_PROT_LPDDR: begin
            o_sel  = 5'h08;
            o_prot = CFGTWO_LPDDR;
         end
         `CFGTWO_PROT_COMB: begin
            o_sel  = 5'h10;
            o_prot = CFGTWO_COMB;
         end
         default: begin
            o_sel  = 5'h00;
            o_prot = CFGTWO_RSVD;
         end
      endcase
      // an unsupported code selects nothing
      if ((o_sel & i_support) == 5'h00) begin
         o_sel  = 5'h00;
         o_prot = CFGTWO_RSVD;
      end
   end
endmodule // cfgtwo_prot_dec

// ---- design/cfgtwo_width_dec.sv ----
/*
 * width decoder: maps the width code onto the number of pad bits in use
 * and a lane mask. assumes the configured bus width as a parameter.
 */
`timescale 1ns/1ns
`include "cfgtwo_params.svh"
module cfgtwo_width_dec #(
   parameter int BUS_BITS = 32
) (
   // code in
   input  wire logic [1:0] i_code,
   // decoded out
   output      logic [6:0] o_bits,
   output      logic [7:0] o_lanes
);
   // lanes for a number of bits
   function automatic logic [7:0] lanes_for(input logic [6:0] b);
      case (b)
         7'h10:   lanes_for = 8'h03;
         7'h20:   lanes_for = 8'h0F;
         default: lanes_for = 8'hFF;
      endcase
   endfunction

   // full or lower-half width per configured bus
   always_comb begin
      o_bits = 7'h10;
      if (BUS_BITS == 32) begin
         o_bits = (i_code == `CFGTWO_WID_01) ? 7'h20 : 7'h10;
      end else if (BUS_BITS == 64) begin
         o_bits = (i_code == `CFGTWO_WID_10) ? 7'h40 : 7'h20;
      end
      o_lanes = lanes_for(o_bits);
   end
endmodule // cfgtwo_width_dec

// ---- verification/cfgtwo_bank_chk.sv ----
/* checker for the setup register bank: bus answer, field ranges,
   protocol decode and pad width hold.
   assumes the top module's ports only; bound below. */
`timescale 1ns/1ns
module cfgtwo_bank_chk #(
   parameter int BUS_BITS = 32
) (
   // clock and resets
   input wire logic        i_mclk,
   input wire logic        i_rst_n,
   input wire logic        i_mem_rst_n,
   // bus
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic        o_wb_ack,
   // configuration
   input wire logic [1:0]  o_capture_delay,
   input wire cfgtwo_pkg::cfgtwo_prot_type o_protocol,
   input wire logic [4:0]  o_protocol_sel,
   input wire logic [6:0]  o_bus_bits,
   input wire logic [7:0]  o_lane_mask
);
   import cfgtwo_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // request taken with no answer outstanding
   sequence s_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   // no memory-side reset release at this edge
   sequence s_mem_quiet;
      i_mem_rst_n && $past(i_mem_rst_n) && $past(i_rst_n);
   endsequence
   chk_ack_next: assert property (s_req |=> o_wb_ack ##1 !o_wb_ack)
      else $error("ack missing or too long");
   chk_ack_cause: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   chk_delay_max: assert property (o_capture_delay <= 2'h2)
      else $error("capture delay above two");
   chk_delay_hold: assert property (!(i_wb_cyc && i_wb_stb && i_wb_we) && $past(i_rst_n)
      |=> $stable(o_capture_delay))
      else $error("capture delay moved without a write");
   chk_sel_decode: assert property (o_protocol != CFGTWO_RSVD
      |-> o_protocol_sel == 5'h01 << o_protocol)
      else $error("protocol select wrong");
   chk_rsvd_none: assert property (o_protocol == CFGTWO_RSVD |-> o_protocol_sel == 5'h00)
      else $error("reserved code selects a protocol");
   chk_width_hold: assert property (s_mem_quiet |=> $stable(o_bus_bits))
      else $error("pad width moved outside memory reset");
   chk_width_range: assert property (o_bus_bits == BUS_BITS || 2 * o_bus_bits == BUS_BITS)
      else $error("pad width not full or half");
   chk_lane_match: assert property (o_lane_mask == (8'h01 << o_bus_bits[6:3]) - 8'h01)
      else $error("lane mask disagrees with width");
endmodule // cfgtwo_bank_chk

bind cfgtwo_bank cfgtwo_bank_chk #(.BUS_BITS(BUS_BITS)) u_chk (.i_mclk, .i_rst_n,
   .i_mem_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .o_wb_ack, .o_capture_delay,
   .o_protocol, .o_protocol_sel, .o_bus_bits, .o_lane_mask);

// ---- verification/cfgtwo_bank_bench.sv ----
/* self-checking bench for the setup register bank: access table,
   pad width apply, protocol decode, second reset.
   assumes the checker file is compiled with it. */
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t got %h expected %h", $time, (g), (e)); end end
module cfgtwo_bank_bench;
   import cfgtwo_pkg::*;
   // one access: direction, address, write data, expected read data
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } cfgtwo_row_type;
   logic i_mclk = 1'b0, i_rst_n = 1'b0, i_mem_rst_n = 1'b0;
   logic [1:0] i_strap_delay = 2'h1, i_strap_width = 2'h1;
   logic [2:0] i_strap_prot = 3'h1, c;
   logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, o_wb_ack;
   logic [7:0] i_wb_adr = 8'h00, o_lane_mask;
   logic [3:0] i_wb_sel = 4'hF;
   logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
   logic [1:0] o_capture_delay;
   logic [4:0] o_protocol_sel;
   logic [6:0] o_bus_bits;
   cfgtwo_prot_type o_protocol;
   int fail_count = 0;
   int cmp_count = 0;
   // straps, overrides, state window, unmapped place
   cfgtwo_row_type rows [16] = '{
      '{1'b0, 8'h00, 32'h0, 32'h250}, '{1'b0, 8'h04, 32'h0, 32'h3F},
      '{1'b0, 8'h08, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'h4C0, 32'h0},
      '{1'b0, 8'h00, 32'h0, 32'h4C0}, '{1'b1, 8'h00, 32'h710, 32'h0},
      '{1'b0, 8'h00, 32'h0, 32'h510}, '{1'b1, 8'h08, 32'h1, 32'h0},
      '{1'b1, 8'h00, 32'h40, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'h510},
      '{1'b1, 8'h08, 32'h3, 32'h0}, '{1'b1, 8'h00, 32'h0, 32'h0},
      '{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b1, 8'h08, 32'h0, 32'h0},
      '{1'b1, 8'h0C, 32'hFFFF, 32'h0}, '{1'b0, 8'h0C, 32'h0, 32'h0}};

   cfgtwo_bank #(.BUS_BITS(32), .COMBINED(1'b1), .SUPPORT(5'h1F)) dut (.i_mclk,
      .i_rst_n, .i_mem_rst_n, .i_strap_delay, .i_strap_prot, .i_strap_width,
      .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
      .o_wb_ack, .o_capture_delay, .o_protocol, .o_protocol_sel, .o_bus_bits,
      .o_lane_mask);

   // 100 ns clock
   always #50 i_mclk = ~i_mclk;

   // one classic bus cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= w;
      i_wb_adr <= a;
      i_wb_dat <= d;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      if (n >= 20) fail_count++;
      r = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we  <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // hang guard, far beyond the hundred or so cycles needed
   initial begin
      repeat (3000) @(posedge i_mclk);
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      foreach (rows[i]) begin
         wb(rows[i].w, rows[i].a, rows[i].d, q);
         if (!rows[i].w) `CHK(q, rows[i].e)
      end
      // width waits for the memory-side reset release
      `CHK(o_bus_bits, 7'h10)
      wb(1'b1, 8'h00, 32'h10, q);
      i_mem_rst_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
      `CHK(o_bus_bits, 7'h20)
      `CHK(o_lane_mask, 8'h0F)
      wb(1'b1, 8'h00, 32'h0, q);
      `CHK(o_bus_bits, 7'h20)
      i_mem_rst_n <= 1'b0;
      @(posedge i_mclk);
      i_mem_rst_n <= 1'b1;
      repeat (2) @(posedge i_mclk);
      `CHK(o_bus_bits, 7'h10)
      `CHK(o_lane_mask, 8'h03)
      // every protocol code, delay codes 0 to 3
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         wb(1'b1, 8'h00, {21'h0, c[1:0], c, 2'b01, 4'h0}, q);
         `CHK(o_protocol, (c < 3'h5) ? cfgtwo_prot_type'(c) : CFGTWO_RSVD)
         `CHK(o_protocol_sel, (c < 3'h5) ? 5'h01 << c : 5'h00)
         `CHK(o_capture_delay, (c[1:0] > 2'h2) ? 2'h2 : c[1:0])
      end
      // second reset with new straps, memory reset already high
      i_strap_delay <= 2'h3;
      i_strap_prot  <= 3'h2;
      i_rst_n       <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(posedge i_mclk);
      wb(1'b0, 8'h00, 32'h0, q);
      `CHK(q, 32'h490)
      `CHK(o_bus_bits, 7'h20)
      report_and_stop();
   end
endmodule // cfgtwo_bank_bench
